// ==== rtl/ctw_consts.vh ====
// constants for the core timer: register offsets, field positions,
// reset values and divider taps; included by every rtl file of the block.
// How it works
// R1 - counter wrap sets overflow flag, read-only
// R2 - overflow flag and enable request interrupt
// R3 - periodic flag on selected divider stage edge
// R4 - periodic flag and enable request interrupt
// R5 - writing one clears overflow flag
// R6 - writing one clears periodic flag
// R7 - rate select picks 2^14..2^17 period
// R8 - reset sets rate bits, clears others
// R9 - reset clears both flags and enables
// R10 - watchdog clocked by periodic output div 8
// R11 - watchdog timeout raises internal reset
// R12 - software writes zero to service watchdog
// R13 - service clears only final watchdog stage
// R14 - counter register returns prescaled 8-bit count
// R15 - power-on holds reset for 4064 cycles
// R16 - external reset clears whole chain
// R17 - wait mode keeps counting, interrupt wakes
// R18 - stop entry clears timer, flags, enables
// R19 - stop exit waits, clears, then resumes
// R20 - software services watchdog before rate change
// R21 - overflow every 1024 operating clocks
// R22 - one interrupt line while enabled flag pending
`ifndef CTW_CONSTS_VH
`define CTW_CONSTS_VH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define CTW_ADDR_W        16
`define CTW_OFS_STATCTL   16'h0008
`define CTW_OFS_COUNT     16'h0009
`define CTW_OFS_WDSERVICE 16'h3ff0

// ------------------------------------------------------------
// status/control fields
// ------------------------------------------------------------
`define CTW_B_OVF         7
`define CTW_B_PER         6
`define CTW_B_OVF_IE      5
`define CTW_B_PER_IE      4
`define CTW_B_OVF_CLR     3
`define CTW_B_PER_CLR     2
`define CTW_B_RATE_HI     1
`define CTW_B_RATE_LO     0
`define CTW_B_WD_SERVICE  0
`define CTW_RATE_RESET    2'h3

// ------------------------------------------------------------
// divider chain: bit k of the chain toggles every 2^k clocks
// ------------------------------------------------------------
`define CTW_CHAIN_W       17
`define CTW_CNT_LSB       2
`define CTW_CNT_MSB       9
`define CTW_PER_BASE      13
`define CTW_WD_W          3
`define CTW_POR_CYCLES    4064

`endif

// ==== rtl/ctw_sync.v ====
// three-stage synchroniser for one asynchronous level input.
// assumes a single clock; output changes once stages two and three agree.
`timescale 1ns/100ps
`default_nettype none
`include "ctw_consts.vh"

module ctw_sync
(
	// clock and reset
	input  wire clock,
	input  wire reset,
	// level in and out
	input  wire din,
	output reg  dout_r
);

	reg s1_r;
	reg s2_r;
	reg s3_r;

	// first stage is read only by the second
	always @(posedge clock)
	begin
		if (reset)
		begin
			s1_r   <= 1'b0;
			s2_r   <= 1'b0;
			s3_r   <= 1'b0;
			dout_r <= 1'b0;
		end
		else
		begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r)
				dout_r <= s3_r;
		end
	end

endmodule
`default_nettype wire

// ==== rtl/ctw_chain.v ====
// free-running timer divider chain with synchronous clear.
// assumes one clock at the operating frequency; clear wins over count.
`timescale 1ns/100ps
`default_nettype none
`include "ctw_consts.vh"

module ctw_chain
#(
	parameter W = `CTW_CHAIN_W
)
(
	// clock and reset
	input  wire         clock,
	input  wire         reset,
	// control
	input  wire         clear,
	// state
	output reg  [W-1:0] chain_r
);

	// binary counter stands in for the ripple stages, one bit per stage
	always @(posedge clock)
	begin
		if (reset || clear)
			chain_r <= {W{1'b0}};
		else
			chain_r <= chain_r + {{(W-1){1'b0}}, 1'b1};
	end

endmodule
`default_nettype wire

// ==== rtl/ctw_core_timer.v ====
// core timer: prescaled 8-bit counter with overflow flag, periodic
// interrupt with four rates, watchdog and power-on reset delay.
// assumes a cpu bus on the same clock, plain strobes, read data next cycle;
// stop and wait levels come from the clock controller on another domain.
`timescale 1ns/100ps
`default_nettype none
`include "ctw_consts.vh"

module ctw_core_timer
#(
	parameter POR_CYCLES = `CTW_POR_CYCLES,
	parameter WD_W       = `CTW_WD_W
)
(
	// clock and reset
	input  wire                   clock,
	input  wire                   reset,
	// register port
	input  wire [`CTW_ADDR_W-1:0] addr,
	input  wire [7:0]             wdata,
	input  wire                   wr_stb,
	input  wire                   rd_stb,
	output reg  [7:0]             rdata_r,
	// low-power mode levels from outside the clock domain
	input  wire                   stop_mode,
	input  wire                   stop_ready,
	input  wire                   wait_mode,
	// results
	output reg                    core_timer_irq_r,
	output reg                    wake_r,
	output reg                    internal_reset_r,
	output reg                    por_busy_r
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	localparam ST_POR  = 2'h0;
	localparam ST_RUN  = 2'h1;
	localparam ST_STOP = 2'h2;

	reg  [1:0]              state_r;
	reg  [1:0]              state_nxt;
	reg  [12:0]             por_cnt_r;
	reg                     overflow_flag_r;
	reg                     periodic_flag_r;
	reg                     overflow_irq_enable_r;
	reg                     periodic_irq_enable_r;
	reg                     rate_select_hi_r;
	reg                     rate_select_lo_r;
	reg  [WD_W-1:0]         wd_cnt_r;
	reg                     tap_prev_r;
	reg                     cnt_msb_prev_r;
	reg                     chain_clear;
	wire [`CTW_CHAIN_W-1:0] chain_r;
	wire                    stop_sync;
	wire                    ready_sync;
	wire                    wait_sync;
	wire [1:0]              rate_sel;
	wire                    tap;
	wire                    ovf_event;
	wire                    per_event;
	wire                    wr_statctl;
	wire                    wr_service;
	wire                    wd_expire;
	wire [1:0]              rate_reset;

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	ctw_sync u_sync_stop
	(
		.clock  (clock),
		.reset  (reset),
		.din    (stop_mode),
		.dout_r (stop_sync)
	);

	ctw_sync u_sync_ready
	(
		.clock  (clock),
		.reset  (reset),
		.din    (stop_ready),
		.dout_r (ready_sync)
	);

	ctw_sync u_sync_wait
	(
		.clock  (clock),
		.reset  (reset),
		.din    (wait_mode),
		.dout_r (wait_sync)
	);

	// ------------------------------------------------------------
	// divider chain
	// ------------------------------------------------------------
	ctw_chain #(.W(`CTW_CHAIN_W)) u_chain
	(
		.clock   (clock),
		.reset   (reset),
		.clear   (chain_clear),
		.chain_r (chain_r)
	);

	// ------------------------------------------------------------
	// event detection
	// ------------------------------------------------------------
	assign rate_sel   = {rate_select_hi_r, rate_select_lo_r};
	assign rate_reset = `CTW_RATE_RESET;
	// stage PER_BASE+sel toggles every 2^(13+sel) clocks: rising edge
	// gives one event per 2^(14+sel) clocks; see R7
	assign tap        = chain_r[`CTW_PER_BASE + rate_sel];
	// msb of the 8-bit count falling means ff -> 00 wrap; see R1 see R21
	// gated to run so a wrap inside the power-on delay leaves no flag behind
	assign ovf_event  = cnt_msb_prev_r & ~chain_r[`CTW_CNT_MSB] &
	                    (state_r == ST_RUN);
	// periodic flag on the rising edge of the chosen stage; see R3
	assign per_event  = tap & ~tap_prev_r & (state_r == ST_RUN);
	assign wr_statctl = wr_stb && (addr == `CTW_OFS_STATCTL);
	// bit 0 written as zero services the watchdog; see R12
	assign wr_service = wr_stb && (addr == `CTW_OFS_WDSERVICE) &&
	                    !wdata[`CTW_B_WD_SERVICE];
	assign wd_expire  = per_event && (&wd_cnt_r);

	// edge history; cleared along with the chain so no false edge
	always @(posedge clock)
	begin
		if (reset || chain_clear)
		begin
			tap_prev_r     <= 1'b0;
			cnt_msb_prev_r <= 1'b0;
		end
		else
		begin
			tap_prev_r     <= tap;
			cnt_msb_prev_r <= chain_r[`CTW_CNT_MSB];
		end
	end

	// ------------------------------------------------------------
	// mode sequencing
	// ------------------------------------------------------------
	// por holds the chain in use for the delay, then clears it once
	always @*
	begin
		state_nxt   = state_r;
		chain_clear = 1'b0;
		case (state_r)
			ST_POR:
			begin
				if (por_cnt_r == POR_CYCLES[12:0] - 13'h0001)
				begin
					state_nxt   = ST_RUN;
					chain_clear = 1'b1;            // see R15
				end
			end
			ST_RUN:
			begin
				// wait mode keeps counting, nothing to do; see R17
				if (stop_sync)
				begin
					state_nxt   = ST_STOP;
					chain_clear = 1'b1;            // see R18
				end
			end
			ST_STOP:
			begin
				chain_clear = 1'b1;                // held while stopped
				// oscillator restart and stabilisation end; see R19
				if (!stop_sync && ready_sync)
					state_nxt = ST_RUN;
			end
			default:
			begin
				state_nxt   = ST_POR;
				chain_clear = 1'b1;
			end
		endcase
	end

	// reset restarts the power-on delay and clears the chain; see R16
	always @(posedge clock)
	begin
		if (reset)
		begin
			state_r   <= ST_POR;
			por_cnt_r <= 13'h0000;
		end
		else
		begin
			state_r <= state_nxt;
			if (state_r == ST_POR)
				por_cnt_r <= por_cnt_r + 13'h0001;
			else
				por_cnt_r <= 13'h0000;
		end
	end

	// ------------------------------------------------------------
	// status and control register
	// ------------------------------------------------------------
	// hardware set beats the same-cycle software clear
	always @(posedge clock)
	begin
		if (reset || (state_r == ST_STOP) || (state_nxt == ST_STOP))
		begin
			overflow_flag_r       <= 1'b0;      // see R9 see R18
			periodic_flag_r       <= 1'b0;
			overflow_irq_enable_r <= 1'b0;
			periodic_irq_enable_r <= 1'b0;
			if (reset)
			begin
				rate_select_hi_r <= rate_reset[1];        // see R8
				rate_select_lo_r <= rate_reset[0];
			end
		end
		else
		begin
			if (ovf_event)
				overflow_flag_r <= 1'b1;                  // see R1
			else if (wr_statctl && wdata[`CTW_B_OVF_CLR])
				overflow_flag_r <= 1'b0;                  // see R5
			if (per_event)
				periodic_flag_r <= 1'b1;                  // see R3
			else if (wr_statctl && wdata[`CTW_B_PER_CLR])
				periodic_flag_r <= 1'b0;                  // see R6
			if (wr_statctl)
			begin
				overflow_irq_enable_r <= wdata[`CTW_B_OVF_IE];
				periodic_irq_enable_r <= wdata[`CTW_B_PER_IE];
				rate_select_hi_r      <= wdata[`CTW_B_RATE_HI];
				rate_select_lo_r      <= wdata[`CTW_B_RATE_LO];
			end
		end
	end

	// ------------------------------------------------------------
	// watchdog
	// ------------------------------------------------------------
	// counts periodic-tap edges; service clears only this stage, so the
	// worst case is eight tap periods after service; see R10 see R13
	always @(posedge clock)
	begin
		if (reset || chain_clear || wr_service)
			wd_cnt_r <= {WD_W{1'b0}};
		else if (per_event)
			wd_cnt_r <= wd_cnt_r + {{(WD_W-1){1'b0}}, 1'b1};
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// one combined line; flags and enables from registers; see R22
	always @(posedge clock)
	begin
		if (reset)
		begin
			core_timer_irq_r <= 1'b0;
			wake_r           <= 1'b0;
			internal_reset_r <= 1'b0;
			por_busy_r       <= 1'b1;
		end
		else
		begin
			core_timer_irq_r <= (overflow_flag_r & overflow_irq_enable_r) |
			                    (periodic_flag_r & periodic_irq_enable_r);
			// see R2 see R4
			wake_r           <= wait_sync &
			                    ((overflow_flag_r & overflow_irq_enable_r) |
			                     (periodic_flag_r & periodic_irq_enable_r));
			// see R17
			internal_reset_r <= wd_expire;                 // see R11
			por_busy_r       <= (state_nxt == ST_POR);
		end
	end

	// read data stand only in the cycle after the strobe
	always @(posedge clock)
	begin
		if (reset || !rd_stb)
			rdata_r <= 8'h00;
		else if (addr == `CTW_OFS_STATCTL)
			rdata_r <= {overflow_flag_r, periodic_flag_r,
			            overflow_irq_enable_r, periodic_irq_enable_r,
			            2'h0, rate_select_hi_r, rate_select_lo_r};
			// strobe bits read zero; see R5 see R6
		else if (addr == `CTW_OFS_COUNT)
			rdata_r <= chain_r[`CTW_CNT_MSB:`CTW_CNT_LSB];  // see R14
		else
			rdata_r <= 8'h00;
	end

endmodule
`default_nettype wire

// ==== test/ctw_core_timer_chk.sv ====
// port checker for the core timer, bound to its top module.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
`include "ctw_consts.vh"

module ctw_core_timer_chk
#(
	parameter POR_CYCLES = 4064
)
(
	// clock and reset
	input wire logic        clock,
	input wire logic        reset,
	// register port
	input wire logic [15:0] addr,
	input wire logic [7:0]  wdata,
	input wire logic        wr_stb,
	input wire logic        rd_stb,
	input wire logic [7:0]  rdata_r,
	// mode levels
	input wire logic        stop_mode,
	input wire logic        stop_ready,
	input wire logic        wait_mode,
	// results
	input wire logic        core_timer_irq_r,
	input wire logic        wake_r,
	input wire logic        internal_reset_r,
	input wire logic        por_busy_r
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	// edges spent in the power-on delay since reset let go
	int por_cnt;
	always @(posedge clock)
	begin
		if (reset)
			por_cnt <= 0;
		else if (por_busy_r)
			por_cnt <= por_cnt + 1;
	end

	sequence s_rd_ctl;
		rd_stb && addr == `CTW_OFS_STATCTL;
	endsequence
	sequence s_rd_cnt;
		rd_stb && addr == `CTW_OFS_COUNT;
	endsequence

	property p_rd_idle;
		!rd_stb |=> rdata_r == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not idle");
	property p_strobe_bits;
		s_rd_ctl |=> rdata_r[3:2] == 2'h0;
	endproperty
	a_strobe_bits: assert property (p_strobe_bits)
		else $error("clear strobes read back set");
	property p_irq_on;
		s_rd_ctl ##1 ((rdata_r[7] && rdata_r[5]) || (rdata_r[6] && rdata_r[4]))
			|-> ##[0:2] core_timer_irq_r;
	endproperty
	a_irq_on: assert property (p_irq_on)
		else $error("enabled flag without irq");
	property p_reset_out;
		$fell(reset) |-> por_busy_r && !core_timer_irq_r && !wake_r
			&& !internal_reset_r && rdata_r == 8'h00;
	endproperty
	a_reset_out: assert property (p_reset_out)
		else $error("outputs wrong after reset");
	// slack of three edges; por_busy_r has no sync stage, so the count comes out at exactly POR_CYCLES
	property p_por_len;
		$fell(por_busy_r) |-> por_cnt >= POR_CYCLES && por_cnt <= POR_CYCLES + 3;
	endproperty
	a_por_len: assert property (p_por_len)
		else $error("power-on delay length wrong");
	property p_wd_pulse;
		internal_reset_r |=> !internal_reset_r;
	endproperty
	a_wd_pulse: assert property (p_wd_pulse)
		else $error("watchdog reset not one cycle");
	property p_cnt_step;
		logic [7:0] v;
		(s_rd_cnt ##1 (1, v = rdata_r)) ##3 s_rd_cnt |=> rdata_r == 8'(v + 8'h01);
	endproperty
	a_cnt_step: assert property (p_cnt_step)
		else $error("count did not step by one");
	property p_stop_clear;
		stop_mode [*8] ##0 rd_stb |=> rdata_r[7:2] == 6'h00;
	endproperty
	a_stop_clear: assert property (p_stop_clear)
		else $error("timer not cleared in stop");
	property p_wake;
		wait_mode [*6] ##0 core_timer_irq_r |-> ##[0:6] wake_r;
	endproperty
	a_wake: assert property (p_wake)
		else $error("no wake from wait");
endmodule

bind ctw_core_timer ctw_core_timer_chk #(.POR_CYCLES(POR_CYCLES)) u_chk
(
	.clock(clock),
	.reset(reset),
	.addr(addr),
	.wdata(wdata),
	.wr_stb(wr_stb),
	.rd_stb(rd_stb),
	.rdata_r(rdata_r),
	.stop_mode(stop_mode),
	.stop_ready(stop_ready),
	.wait_mode(wait_mode),
	.core_timer_irq_r(core_timer_irq_r),
	.wake_r(wake_r),
	.internal_reset_r(internal_reset_r),
	.por_busy_r(por_busy_r)
);
`default_nettype wire

// ==== test/tb_top.sv ====
// self-checking bench for the core timer, driving its ports directly.
// assumes the port checker is bound in; power-on delay shortened to 16.
`timescale 1ns/100ps
`default_nettype none
`include "ctw_consts.vh"

module tb_top;
	logic        clock = 1'b0;
	logic        reset = 1'b1;
	logic [15:0] addr = 16'h0000;
	logic [7:0]  wdata = 8'h00;
	logic        wr_stb = 1'b0;
	logic        rd_stb = 1'b0;
	logic        stop_mode = 1'b0;
	logic        stop_ready = 1'b1;
	logic        wait_mode = 1'b0;
	wire  [7:0]  rdata_r;
	wire         irq;
	wire         wake_r;
	wire         por_busy_r;
	wire         wd_rst;
	int          n_errors = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          t1;
	int          t2;
	logic [7:0]  d;
	// rows: address, write data, read mask, expected read
	logic [39:0] rows [7] = '{
		{16'h0008, 8'h3f, 8'h3f, 8'h33}, {16'h0008, 8'h01, 8'h3f, 8'h01},
		{16'h0008, 8'h02, 8'h3f, 8'h02}, {16'h0008, 8'h10, 8'h3f, 8'h10},
		{16'h0008, 8'h23, 8'h3f, 8'h23}, {16'h0040, 8'hff, 8'hff, 8'h00},
		{16'h0008, 8'h00, 8'h3f, 8'h00}};

	always #20 clock = ~clock;
	always @(posedge clock) cyc <= cyc + 1;

	ctw_core_timer #(.POR_CYCLES(16)) uut
	(
		.clock(clock),
		.reset(reset),
		.addr(addr),
		.wdata(wdata),
		.wr_stb(wr_stb),
		.rd_stb(rd_stb),
		.rdata_r(rdata_r),
		.stop_mode(stop_mode),
		.stop_ready(stop_ready),
		.wait_mode(wait_mode),
		.core_timer_irq_r(irq),
		.wake_r(wake_r),
		.internal_reset_r(wd_rst),
		.por_busy_r(por_busy_r)
	);

	// ------------------------------------------------------------
	// bus and check tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge clock);
		addr <= a;
		wdata <= v;
		wr_stb <= 1'b1;
		@(posedge clock);
		wr_stb <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge clock);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clock);
		rd_stb <= 1'b0;
		#1 v = rdata_r;
	endtask
	// bounded wait for the irq, returning the cycle it was seen
	task automatic wait_irq(input int lim, output int t);
		int i = 0;
		while (irq !== 1'b1 && i < lim)
		begin
			@(posedge clock);
			#1 i++;
		end
		chk("irq wait", i < lim, 1'b1);
		t = cyc;
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// watchdog: the run needs about 25000 cycles
	initial
	begin
		#(50000 * 40);
		n_errors++;
		wrap_up();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (20) @(posedge clock);
		reset <= 1'b0;
		rd(`CTW_OFS_STATCTL, d);
		chk("ctl reset", d, 8'h03);
		chk("por busy", por_busy_r, 1'b1);
		repeat (30) @(posedge clock);
		chk("por done", por_busy_r, 1'b0);
		foreach (rows[k])
		begin
			wr(rows[k][39:24], rows[k][23:16]);
			rd(rows[k][39:24], d);
			chk("reg row", d & rows[k][15:8], rows[k][7:0]);
		end
		$display("register test done");
		// overflow spacing, then wake out of wait
		wr(`CTW_OFS_STATCTL, 8'h28);
		repeat (3) @(posedge clock);
		wait_irq(1100, t1);
		rd(`CTW_OFS_STATCTL, d);
		chk("ovf flag", d[7], 1'b1);
		wr(`CTW_OFS_STATCTL, 8'h28);
		repeat (3) @(posedge clock);
		chk("ovf irq clear", irq, 1'b0);
		wait_mode <= 1'b1;
		wait_irq(1100, t2);
		chk("ovf period", t2 - t1, 1024);
		repeat (8) @(posedge clock);
		chk("wake", wake_r, 1'b1);
		wait_mode <= 1'b0;
		rd(`CTW_OFS_COUNT, t1[7:0]);
		repeat (2) @(posedge clock);
		rd(`CTW_OFS_COUNT, d);
		chk("count step", d, 8'(t1[7:0] + 8'h01));
		$display("overflow test done");
		// periodic flag at the fastest rate
		wr(`CTW_OFS_STATCTL, 8'h14);
		repeat (3) @(posedge clock);
		wait_irq(17000, t1);
		rd(`CTW_OFS_STATCTL, d);
		chk("per flag", d[6], 1'b1);
		wr(`CTW_OFS_STATCTL, 8'h14);
		repeat (3) @(posedge clock);
		chk("per irq clear", irq, 1'b0);
		wait_irq(17000, t2);
		chk("per period", t2 - t1, 16384);
		wr(`CTW_OFS_WDSERVICE, 8'h00);
		$display("periodic test done");
		// stop clears all but the rate, restart waits for stop_ready
		stop_mode <= 1'b1;
		stop_ready <= 1'b0;
		repeat (10) @(posedge clock);
		rd(`CTW_OFS_STATCTL, d);
		chk("stop ctl", d, 8'h00);
		rd(`CTW_OFS_COUNT, d);
		chk("stop count", d, 8'h00);
		@(posedge clock);
		stop_mode <= 1'b0;
		repeat (10) @(posedge clock);
		rd(`CTW_OFS_COUNT, d);
		chk("held count", d, 8'h00);
		@(posedge clock);
		stop_ready <= 1'b1;
		repeat (400) @(posedge clock);
		rd(`CTW_OFS_COUNT, d);
		chk("resumed", d > 8'h10, 1'b1);
		$display("stop test done");
		// second reset mid-run clears the chain again
		@(posedge clock);
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		rd(`CTW_OFS_STATCTL, d);
		chk("ctl reset 2", d, 8'h03);
		repeat (30) @(posedge clock);
		rd(`CTW_OFS_COUNT, d);
		chk("count restart", d < 8'h10, 1'b1);
		chk("no wd reset", wd_rst, 1'b0);
		$display("reset test done");
		wrap_up();
	end
endmodule
`default_nettype wire
